// ### core/rscl_consts.svh
// Constants of the reset strap configuration latch: offsets, field positions,
// reset values, the address width and strap codes.
// Assumes inclusion by bare name from the design files of this block.
`ifndef RSCL_CONSTS_SVH
`define RSCL_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RSCL_ADDR_W 8
`define RSCL_OFF_CONFIG 8'h00
`define RSCL_OFF_CONTROL 8'h04
`define RSCL_OFF_STATUS 8'h08

// ----------------------------------------------------------------
// Latched configuration register fields
// ----------------------------------------------------------------
`define RSCL_CFG_STRAPS_LSB 0
`define RSCL_CFG_BUS_START 4
`define RSCL_CFG_SUSP_STRAP 5
`define RSCL_CFG_VARIANT_LSB 6
`define RSCL_CFG_BIG_ENDIAN 9
`define RSCL_CFG_HW_SUSP_EN 10
`define RSCL_CFG_RESERVED 11
`define RSCL_CFG_WIDTH_16 12
`define RSCL_CFG_VALID 13

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define RSCL_CTL_SW_SUSPEND 0
`define RSCL_CTL_PANEL_EN 1
`define RSCL_CTL_CLK_DIV_EN 2
`define RSCL_CTL_SW_SUSPEND_RST 1'b0
`define RSCL_CTL_PANEL_EN_RST 1'b0
`define RSCL_CTL_CLK_DIV_EN_RST 1'b0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define RSCL_STA_POWER_SAVE 0
`define RSCL_STA_HW_SUSP_ACT 1
`define RSCL_STA_PANEL_POWER 2

// ----------------------------------------------------------------
// Strap codes of the host bus variants
// ----------------------------------------------------------------
`define RSCL_CODE_PROC1 3'h0
`define RSCL_CODE_PROC2 3'h1
`define RSCL_CODE_M68K1 3'h3
`define RSCL_CODE_M68K2 3'h5
`define RSCL_CODE_GENERIC 3'h7

`endif

// ### core/rscl_pkg.sv
// Types of the reset strap configuration latch.
// Assumes rscl_consts.svh is not needed here; types only.
`default_nettype none

package rscl_pkg;

  // Host bus variant chosen by the straps
  typedef enum logic [2:0] {
    RSCL_BUS_PROC1 = 3'h0,
    RSCL_BUS_PROC2 = 3'h1,
    RSCL_BUS_M68K1 = 3'h2,
    RSCL_BUS_M68K2 = 3'h3,
    RSCL_BUS_GENERIC1 = 3'h4,
    RSCL_BUS_GENERIC2 = 3'h5,
    RSCL_BUS_RESERVED = 3'h7
  } rscl_bus_type;

  // Capture sequence
  typedef enum logic [0:0] {
    RSCL_ARMED = 1'b0,
    RSCL_HELD = 1'b1
  } rscl_cap_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rscl_apb_state_type;

  typedef struct packed {
    rscl_cap_type cap;
    logic [3:0] straps;
    logic bus_start;
    logic susp_strap;
    rscl_bus_type variant;
    logic reserved;
    logic big_endian;
    logic generic_second;
    logic hw_susp_en;
    logic sw_suspend;
    logic panel_en;
    logic clk_div_en;
    logic hw_susp_act;
    logic power_save;
    logic panel_power;
  } rscl_top_state_type;

endpackage

`default_nettype wire

// ### core/rscl_strap_decode.sv
// Decoder from raw strap levels to host bus variant.
// Assumes straps are sampled by the caller; purely combinational.
`default_nettype none
`include "rscl_consts.svh"

module rscl_strap_decode (
  input wire logic [2:0] bus_code,
  input wire logic bus_start_n,
  output rscl_pkg::rscl_bus_type variant,
  output logic reserved
);

  always_comb begin
    reserved = 1'b0;
    unique case (bus_code)
      `RSCL_CODE_PROC1: begin
        variant = rscl_pkg::RSCL_BUS_PROC1;
      end
      `RSCL_CODE_PROC2: begin
        variant = rscl_pkg::RSCL_BUS_PROC2;
      end
      `RSCL_CODE_M68K1: begin
        variant = rscl_pkg::RSCL_BUS_M68K1;
      end
      `RSCL_CODE_M68K2: begin
        variant = rscl_pkg::RSCL_BUS_M68K2;
      end
      `RSCL_CODE_GENERIC: begin
        // RULE5 - bus start picks generic
        variant = bus_start_n ? rscl_pkg::RSCL_BUS_GENERIC2 : rscl_pkg::RSCL_BUS_GENERIC1;
      end
      default: begin
        variant = rscl_pkg::RSCL_BUS_RESERVED;
        reserved = 1'b1;
      end
    endcase
  end

endmodule

`default_nettype wire

// ### core/rscl_apb_slave.sv
// APB slave front end: handshake, address decode, read mux.
// Assumes an APB master on the same clock; one wait state per access.
`default_nettype none
`include "rscl_consts.svh"

module rscl_apb_slave (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] rd_config,
  input wire logic [31:0] rd_control,
  input wire logic [31:0] rd_status,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ctl_wr
);

  rscl_pkg::rscl_apb_state_type state;
  rscl_pkg::rscl_apb_state_type next_state;
  logic hit;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `RSCL_OFF_CONFIG: begin
        rd_mux = rd_config;
      end
      `RSCL_OFF_CONTROL: begin
        rd_mux = rd_control;
      end
      `RSCL_OFF_STATUS: begin
        rd_mux = rd_status;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    if (psel && penable && !state.pready) begin
      next_state.pready = 1'b1;
      next_state.pslverr = !hit;
      if (!pwrite) begin
        next_state.prdata = rd_mux;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ctl_wr = psel && penable && state.pready && pwrite && (paddr == `RSCL_OFF_CONTROL);
  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;

endmodule

`default_nettype wire

// ### core/rscl_top.sv
// Reset strap configuration latch with APB register access.
// Assumes strap pins steady around reset release and an APB master on REF_CLK.
//
// Summary of operation
// RULE1 - The straps and bus start pin are captured as reset releases and become the configuration.
// RULE2 - The low three strap bits pick the host bus variant, with codes 010, 100 and 110 reserved.
// RULE3 - The host bus is reported sixteen bits wide for every variant.
// RULE4 - The fourth strap bit high selects big endian, low selects little endian.
// RULE5 - With the generic code, bus start low picks the first generic bus and high the second.
// RULE6 - Power save is entered by software or by the hardware suspend pin when that was strapped on.
// RULE7 - The panel power output is driven active high only.
// RULE8 - The display clock source stays under 50MHz with the divider and 25MHz without it.
// RULE9 - The captured configuration holds until the next reset, whatever the straps do later.
`default_nettype none
`include "rscl_consts.svh"

module rscl_top (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] CONFIG_STRAPS,
  input wire logic BUS_START_N,
  input wire logic SUSPEND_STRAP_PIN,
  output logic [2:0] BUS_VARIANT,
  output logic BUS_WIDTH_16,
  output logic BIG_ENDIAN,
  output logic GENERIC_SECOND,
  output logic RESERVED_CODE,
  output logic HW_SUSPEND_EN,
  output logic CONFIG_VALID,
  output logic POWER_SAVE,
  output logic PANEL_POWER_CTL,
  output logic CLK_DIV_EN
);

  rscl_pkg::rscl_top_state_type state;
  rscl_pkg::rscl_top_state_type next_state;
  rscl_pkg::rscl_bus_type dec_variant;
  logic dec_reserved;
  logic ctl_wr;
  logic [31:0] rd_config;
  logic [31:0] rd_control;
  logic [31:0] rd_status;
  logic held;

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  // RULE2 - variant from code
  rscl_strap_decode u_decode (
    .bus_code(CONFIG_STRAPS[2:0]),
    .bus_start_n(BUS_START_N),
    .variant(dec_variant),
    .reserved(dec_reserved)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  rscl_apb_slave u_apb (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .rd_config(rd_config),
    .rd_control(rd_control),
    .rd_status(rd_status),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .ctl_wr(ctl_wr)
  );

  assign held = (state.cap == rscl_pkg::RSCL_HELD);

  // ----------------------------------------------------------------
  // Read images
  // ----------------------------------------------------------------
  always_comb begin
    rd_config = 32'h0000_0000;
    rd_config[`RSCL_CFG_STRAPS_LSB +: 4] = state.straps;
    rd_config[`RSCL_CFG_BUS_START] = state.bus_start;
    rd_config[`RSCL_CFG_SUSP_STRAP] = state.susp_strap;
    rd_config[`RSCL_CFG_VARIANT_LSB +: 3] = state.variant;
    rd_config[`RSCL_CFG_BIG_ENDIAN] = state.big_endian;
    rd_config[`RSCL_CFG_HW_SUSP_EN] = state.hw_susp_en;
    rd_config[`RSCL_CFG_RESERVED] = state.reserved;
    // RULE3 - sixteen bits once captured (held)
    rd_config[`RSCL_CFG_WIDTH_16] = held;
    rd_config[`RSCL_CFG_VALID] = held;
  end

  always_comb begin
    rd_control = 32'h0000_0000;
    rd_control[`RSCL_CTL_SW_SUSPEND] = state.sw_suspend;
    rd_control[`RSCL_CTL_PANEL_EN] = state.panel_en;
    rd_control[`RSCL_CTL_CLK_DIV_EN] = state.clk_div_en;
  end

  always_comb begin
    rd_status = 32'h0000_0000;
    rd_status[`RSCL_STA_POWER_SAVE] = state.power_save;
    rd_status[`RSCL_STA_HW_SUSP_ACT] = state.hw_susp_act;
    rd_status[`RSCL_STA_PANEL_POWER] = state.panel_power;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state.cap)
      rscl_pkg::RSCL_ARMED: begin
        // RULE1 - capture at release
        next_state.straps = CONFIG_STRAPS;
        next_state.bus_start = BUS_START_N;
        next_state.susp_strap = SUSPEND_STRAP_PIN;
        next_state.variant = dec_variant;
        next_state.reserved = dec_reserved;
        // RULE4 - endian strap
        next_state.big_endian = CONFIG_STRAPS[3];
        next_state.generic_second = (dec_variant == rscl_pkg::RSCL_BUS_GENERIC2);
        // RULE6 - suspend enable strap
        next_state.hw_susp_en = SUSPEND_STRAP_PIN;
        next_state.cap = rscl_pkg::RSCL_HELD;
      end
      rscl_pkg::RSCL_HELD: begin
        // RULE9 - hold until reset
        next_state.cap = rscl_pkg::RSCL_HELD;
      end
    endcase

    if (ctl_wr) begin
      next_state.sw_suspend = PWDATA[`RSCL_CTL_SW_SUSPEND];
      next_state.panel_en = PWDATA[`RSCL_CTL_PANEL_EN];
      // RULE8 - divider select
      next_state.clk_div_en = PWDATA[`RSCL_CTL_CLK_DIV_EN];
    end

    // RULE6 - software or hardware suspend
    next_state.hw_susp_act = held && state.hw_susp_en && !SUSPEND_STRAP_PIN;
    next_state.power_save = next_state.sw_suspend || next_state.hw_susp_act;
    // RULE7 - panel power active high
    next_state.panel_power = next_state.panel_en && !next_state.power_save;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= '0;
      state.cap <= rscl_pkg::RSCL_ARMED;
      state.variant <= rscl_pkg::RSCL_BUS_PROC1;
      state.sw_suspend <= `RSCL_CTL_SW_SUSPEND_RST;
      state.panel_en <= `RSCL_CTL_PANEL_EN_RST;
      state.clk_div_en <= `RSCL_CTL_CLK_DIV_EN_RST;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign BUS_VARIANT = state.variant;
  assign BUS_WIDTH_16 = held;
  assign BIG_ENDIAN = state.big_endian;
  assign GENERIC_SECOND = state.generic_second;
  assign RESERVED_CODE = state.reserved;
  assign HW_SUSPEND_EN = state.hw_susp_en;
  assign CONFIG_VALID = held;
  assign POWER_SAVE = state.power_save;
  assign PANEL_POWER_CTL = state.panel_power;
  assign CLK_DIV_EN = state.clk_div_en;

endmodule

`default_nettype wire

// ### tb/rscl_strap_board.sv
// Board strap switches and pull jumpers ahead of the latch.
// Assumes the bench moves a strap or bus start setting only under reset or to test that it is ignored; the suspend pin also moves live.
`default_nettype none
module rscl_strap_board (
  input wire logic [3:0] set_straps,
  input wire logic set_bs,
  input wire logic set_susp,
  output logic [3:0] config_straps,
  output logic bus_start_n,
  output logic suspend_strap_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign config_straps = set_straps;
  assign bus_start_n = set_bs;
  assign suspend_strap_pin = set_susp;
endmodule
`default_nettype wire

// ### tb/rscl_top_properties.sv
// Port checker of the strap latch.
// Assumes one clock domain and a bind onto rscl_top.
`default_nettype none
module rscl_top_chk (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] CONFIG_STRAPS,
  input wire logic BUS_START_N,
  input wire logic SUSPEND_STRAP_PIN,
  input wire logic [2:0] BUS_VARIANT,
  input wire logic BUS_WIDTH_16,
  input wire logic BIG_ENDIAN,
  input wire logic GENERIC_SECOND,
  input wire logic RESERVED_CODE,
  input wire logic HW_SUSPEND_EN,
  input wire logic CONFIG_VALID,
  input wire logic POWER_SAVE,
  input wire logic PANEL_POWER_CTL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  a_capture_valid: assert property (
    ARST_N && !CONFIG_VALID |=> CONFIG_VALID) else $error("config not valid after release");
  a_reserved_code: assert property (
    ARST_N && !CONFIG_VALID |=> RESERVED_CODE == ($past(CONFIG_STRAPS[2:0]) inside {3'h2, 3'h4, 3'h6}))
    else $error("reserved flag wrong");
  a_width_sixteen: assert property (
    ARST_N && !CONFIG_VALID |=> BUS_WIDTH_16) else $error("bus width not 16");
  a_endian_capture: assert property (
    ARST_N && !CONFIG_VALID |=> BIG_ENDIAN == $past(CONFIG_STRAPS[3])) else $error("endian wrong");
  a_generic_select: assert property (
    ARST_N && !CONFIG_VALID && CONFIG_STRAPS[2:0] == 3'h7 |=> GENERIC_SECOND == $past(BUS_START_N))
    else $error("generic choice wrong");
  a_hw_suspend: assert property (
    HW_SUSPEND_EN && !SUSPEND_STRAP_PIN |=> POWER_SAVE) else $error("hw suspend missed");
  a_panel_high: assert property (
    PREADY && PSEL && PWRITE && PADDR == 8'h04 && PWDATA[1:0] == 2'b10 && SUSPEND_STRAP_PIN
    |-> ##[1:2] PANEL_POWER_CTL) else $error("panel power not high");
  a_config_hold: assert property (
    CONFIG_VALID |=> $stable(BUS_VARIANT) && $stable(BIG_ENDIAN) && $stable(HW_SUSPEND_EN) && $stable(GENERIC_SECOND))
    else $error("config changed");
  a_slave_error: assert property (
    PREADY && PSEL |-> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08})) else $error("slave error wrong");
endmodule
bind rscl_top rscl_top_chk chk_i (.REF_CLK, .ARST_N, .PSEL, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR,
  .CONFIG_STRAPS, .BUS_START_N, .SUSPEND_STRAP_PIN, .BUS_VARIANT, .BUS_WIDTH_16, .BIG_ENDIAN,
  .GENERIC_SECOND, .RESERVED_CODE, .HW_SUSPEND_EN, .CONFIG_VALID, .POWER_SAVE, .PANEL_POWER_CTL);
`default_nettype wire

// ### tb/rscl_top_test.sv
// Testbench of the strap latch: strap sweeps over resets, then APB control.
// Assumes the board model drives the strap pins.
`default_nettype none
module rscl_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, BUS_WIDTH_16, BIG_ENDIAN, GENERIC_SECOND, RESERVED_CODE, err;
  logic HW_SUSPEND_EN, CONFIG_VALID, POWER_SAVE, PANEL_POWER_CTL, CLK_DIV_EN;
  logic BUS_START_N, SUSPEND_STRAP_PIN, set_bs = 1'b0, set_susp = 1'b0;
  logic [3:0] CONFIG_STRAPS, set_straps = 4'h0, s;
  logic [2:0] BUS_VARIANT, v;
  logic [2:0] vtab [8] = '{3'h0, 3'h1, 3'h7, 3'h2, 3'h7, 3'h3, 3'h7, 3'h4};
  int fail_count = 0;
  int n_checks = 0;

  always #4 REF_CLK = ~REF_CLK;

  rscl_strap_board board (.set_straps, .set_bs, .set_susp, .config_straps(CONFIG_STRAPS),
    .bus_start_n(BUS_START_N), .suspend_strap_pin(SUSPEND_STRAP_PIN));
  rscl_top uut (.REF_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .CONFIG_STRAPS, .BUS_START_N, .SUSPEND_STRAP_PIN, .BUS_VARIANT, .BUS_WIDTH_16, .BIG_ENDIAN,
    .GENERIC_SECOND, .RESERVED_CODE, .HW_SUSPEND_EN, .CONFIG_VALID, .POWER_SAVE, .PANEL_POWER_CTL, .CLK_DIV_EN);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      fail_count++;
      stop_test();
    end else begin
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask

  task automatic boot(input logic [3:0] st, input logic bs, input logic sp);
    @(posedge REF_CLK);
    ARST_N <= 1'b0;
    set_straps <= st;
    set_bs <= bs;
    set_susp <= sp;
    repeat (4) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    repeat (2) @(posedge REF_CLK);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) begin
      s = 4'(i);
      v = vtab[s[2:0]] + {2'b00, s[2:0] == 3'h7 && s[3]};
      boot(s, s[3], s[0]);
      chk(BUS_VARIANT, v);
      chk(RESERVED_CODE, v == 3'h7);
      chk(GENERIC_SECOND, v == 3'h5);
      chk(BIG_ENDIAN, s[3]);
      chk(BUS_WIDTH_16, 1'b1);
      chk(HW_SUSPEND_EN, s[0]);
      chk(CONFIG_VALID, 1'b1);
      chk(POWER_SAVE, 1'b0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {18'h0, 2'b11, v == 3'h7, s[0], s[3], v, s[0], s[3], s});
    end
    set_straps <= 4'h0;
    set_bs <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h377f);
    chk(BUS_VARIANT, 3'h5);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h04, 32'h6);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h6);
    chk(PANEL_POWER_CTL, 1'b1);
    chk(CLK_DIV_EN, 1'b1);
    set_susp <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    chk(POWER_SAVE, 1'b1);
    chk(PANEL_POWER_CTL, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h3);
    chk(HW_SUSPEND_EN, 1'b1);
    set_susp <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    chk(POWER_SAVE, 1'b0);
    apb(1'b1, 8'h04, 32'h3);
    repeat (2) @(posedge REF_CLK);
    chk(POWER_SAVE, 1'b1);
    chk(PANEL_POWER_CTL, 1'b0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    ARST_N <= 1'b0;
    @(posedge REF_CLK);
    chk(CONFIG_VALID, 1'b0);
    chk(POWER_SAVE, 1'b0);
    chk(CLK_DIV_EN, 1'b0);
    ARST_N <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    chk(BUS_VARIANT, 3'h0);
    chk(BIG_ENDIAN, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
